// [dv/cpu_register_set_bench.sv]
// testbench for the cpu register set with sequencer model
`timescale 1ns/100ps
module cpu_register_set_bench
   import crs_pkg::*;
;
   logic        aclk = 1'b0;
   logic        aresetn = 1'b0;
   logic        timer_irq_req = 1'b0;
   logic        ext_irq_req = 1'b0;
   crs_cmd_s    cmd;
   crs_view_s   view;
   logic [7:0]  s_axi_awaddr = 8'h00;
   logic        s_axi_awvalid = 1'b0;
   logic        s_axi_awready;
   logic [31:0] s_axi_wdata = 32'h0000_0000;
   logic [3:0]  s_axi_wstrb = 4'hF;
   logic        s_axi_wvalid = 1'b0;
   logic        s_axi_wready;
   logic [1:0]  s_axi_bresp;
   logic        s_axi_bvalid;
   logic        s_axi_bready = 1'b0;
   logic [7:0]  s_axi_araddr = 8'h00;
   logic        s_axi_arvalid = 1'b0;
   logic        s_axi_arready;
   logic [31:0] s_axi_rdata;
   logic [1:0]  s_axi_rresp;
   logic        s_axi_rvalid;
   logic        s_axi_rready = 1'b0;
   int          mismatches = 0;
   int          cmp_count = 0;

   crs_core crs_core_i (.aclk(aclk), .aresetn(aresetn), .cmd(cmd),
      .timer_irq_req(timer_irq_req), .ext_irq_req(ext_irq_req), .view(view),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready));

   crs_seq_model crs_seq_model_i (.aclk(aclk), .view(view), .cmd(cmd));

   // 125 mhz clock
   initial begin
      forever #4 aclk = ~aclk;
   end

   task automatic chk(input string nm, input logic [31:0] e,
                      input logic [31:0] s);
      cmp_count++;
      if (s !== e) begin
         mismatches++;
         $display("[ERR] %s expected %h seen %h", nm, e, s);
      end
   endtask

   task automatic final_report();
      $display("mismatches %0d comparisons %0d", mismatches, cmp_count);
      if (mismatches == 0 && cmp_count > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   // axi write: both channels offered together, each dropped when taken
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                         input logic [1:0] er);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      // no cycle count assumed; only the watchdog ends a hung wait
      do begin
         @(posedge aclk);
         if (s_axi_awvalid && s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1);
      chk("bvalid", 1'b1, s_axi_bvalid);
      chk("bresp", er, s_axi_bresp);
      s_axi_bready <= 1'b0;
   endtask

   // axi read: rready held until the data is sampled
   task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed,
                         input logic [1:0] er);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_arvalid && s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1);
      chk("rvalid", 1'b1, s_axi_rvalid);
      chk("rdata", ed, s_axi_rdata);
      chk("rresp", er, s_axi_rresp);
      s_axi_rready <= 1'b0;
   endtask

   task automatic alu(input crs_alu_e o, input logic [7:0] b, input logic ci);
      crs_cmd_s c;
      c = '0;
      c.alu_op = o;
      c.alu_b = b;
      c.cin_ext = ci;
      crs_seq_model_i.send(c);
   endtask

   task automatic stk(input crs_stk_e o);
      crs_cmd_s c;
      c = '0;
      c.stk_op = o;
      crs_seq_model_i.send(c);
   endtask

   task automatic flg(input crs_flg_e o, input logic [7:0] d);
      crs_cmd_s c;
      c = '0;
      c.flg_op = o;
      c.flg_d = d;
      crs_seq_model_i.send(c);
   endtask

   task automatic ea_chk(input crs_ea_e m, input logic [15:0] off,
                         input logic [15:0] ex);
      crs_cmd_s c;
      c = '0;
      c.ea_mode = m;
      c.ea_off = off;
      crs_seq_model_i.send(c);
      chk("ea_valid", 1'b1, view.ea_valid);
      chk("ea", ex, view.ea);
   endtask

   // follow a multi-byte stack burst; counts strobes, bounded wait
   task automatic wait_idle(output int pu, output int pl, output logic early);
      int n;
      pu = 0;
      pl = 0;
      early = 1'b0;
      n = 0;
      while (view.busy === 1'b1 && n < 20) begin
         @(posedge aclk);
         #1;
         n++;
         if (view.push_stb === 1'b1) pu++;
         if (view.pull_stb === 1'b1) pl++;
         if (view.push_stb === 1'b1 && view.flags[F_I] !== 1'b0) early = 1'b1;
      end
   endtask

   task automatic pulse(input logic ext);
      @(posedge aclk);
      if (ext) ext_irq_req <= 1'b1;
      else timer_irq_req <= 1'b1;
      @(posedge aclk);
      ext_irq_req <= 1'b0;
      timer_irq_req <= 1'b0;
      #1;
   endtask

   // mid-run reset must set the mask again even after software cleared it
   task automatic t_reset(input logic mid);
      if (mid) begin
         flg(FLG_CLI, 8'h00);
         @(posedge aclk);
         aresetn <= 1'b0;
         repeat (2) @(posedge aclk);
         aresetn <= 1'b1;
         #1;
      end
      chk("stack_ptr", 13'h00FF, view.stack_ptr);
      chk("flags", 8'hE8, view.flags);
      chk("fetch top", 3'b000, view.fetch_pointer[15:13]);
      $display("test reset done");
   endtask

   task automatic t_alu();
      crs_cmd_s c;
      crs_cmd_s f;
      c = '0;
      c.acc_we = 1'b1;
      c.acc_d = 8'h0F;
      crs_seq_model_i.send(c);
      alu(ALU_ADD, 8'h01, 1'b0);
      chk("add", 8'h10, view.acc);
      chk("flags", 8'hF8, view.flags);
      alu(ALU_ADD, 8'hF0, 1'b0);
      chk("flags", 8'hEB, view.flags);
      alu(ALU_ADC, 8'h0F, 1'b0);
      chk("adc", 8'h10, view.acc);
      chk("flags", 8'hF8, view.flags);
      alu(ALU_SUB, 8'h20, 1'b0);
      chk("sub", 8'hF0, view.acc);
      chk("nzc", 3'b101, view.flags[2:0]);
      alu(ALU_SHIFT, 8'h00, 1'b1);
      chk("zc", 2'b11, view.flags[1:0]);
      // borrow in, explicit carry ops, plain load, bit-test carry
      flg(FLG_SEC, 8'h00);
      alu(ALU_SBC, 8'h01, 1'b0);
      chk("sbc", 8'hFE, view.acc);
      chk("sbc c", 1'b1, view.flags[F_C]);
      flg(FLG_CLC, 8'h00);
      chk("clc", 1'b0, view.flags[F_C]);
      alu(ALU_LOAD, 8'h80, 1'b0);
      chk("load", 8'h80, view.acc);
      chk("load nzc", 3'b100, view.flags[2:0]);
      f = '0;
      f.flg_op = FLG_CARRY;
      f.cin_ext = 1'b1;
      crs_seq_model_i.send(f);
      chk("bit test c", 1'b1, view.flags[F_C]);
      c.acc_d = 8'h12;
      c.idx_we = 1'b1;
      c.idx_d = 8'h10;
      crs_seq_model_i.send(c);
      alu(ALU_PROD, 8'h00, 1'b0);
      chk("prod", 16'h0120, {view.idx, view.acc});
      chk("prod hc", 2'b00, {view.flags[F_H], view.flags[F_C]});
      $display("test alu done");
   endtask

   task automatic t_ea();
      crs_cmd_s c;
      c = '0;
      c.idx_we = 1'b1;
      c.idx_d = 8'h42;
      crs_seq_model_i.send(c);
      ea_chk(EA_IX0, 16'hFFFF, 16'h0042);
      ea_chk(EA_IX1, 16'h00F0, 16'h0132);
      ea_chk(EA_IX2, 16'h1234, 16'h1276);
      $display("test ea done");
   endtask

   // full 64-byte lap, then pull across the wrap and reload
   task automatic t_stack();
      for (int i = 0; i < 64; i++) begin
         stk(STK_PUSH);
         chk("push stb", 1'b1, view.push_stb);
         chk("push addr", 16'h00FF - 16'(i), view.stk_addr);
      end
      chk("wrap", 13'h00FF, view.stack_ptr);
      stk(STK_PULL);
      chk("pull ptr", 13'h00C0, view.stack_ptr);
      chk("pull addr", 16'h00C0, view.stk_addr);
      stk(STK_RELOAD);
      chk("reload", 13'h00FF, view.stack_ptr);
      $display("test stack done");
   endtask

   task automatic t_pc();
      crs_cmd_s c;
      c = '0;
      c.fetch_op = FP_LOAD;
      c.fetch_d = 13'h1FFF;
      crs_seq_model_i.send(c);
      chk("fetch load", 16'h1FFF, view.fetch_pointer);
      c.fetch_op = FP_INC;
      crs_seq_model_i.send(c);
      chk("fetch inc", 16'h0000, view.fetch_pointer);
      $display("test pc done");
   endtask

   task automatic t_irq();
      int   pu;
      int   pl;
      logic early;
      axi_wr(REG_CTRL, 32'h0000_0001, RESP_OKAY);
      pulse(1'b1);
      chk("pend", 2'b10, view.pend);
      chk("take", 1'b0, view.irq_take);
      flg(FLG_CLI, 8'h00);
      @(posedge aclk);
      #1;
      chk("take", 1'b1, view.irq_take);
      stk(STK_INTR);
      wait_idle(pu, pl, early);
      chk("pushes", 5, pu);
      chk("mask early", 1'b0, early);
      chk("vec", 1'b1, view.vec_fetch);
      chk("mask", 1'b1, view.flags[F_I]);
      chk("stack_ptr", 13'h00FA, view.stack_ptr);
      chk("pend", 2'b00, view.pend);
      @(posedge aclk);
      #1;
      chk("vector", 16'h1FFC, view.fetch_pointer);
      stk(STK_IRET);
      wait_idle(pu, pl, early);
      chk("pulls", 5, pl);
      chk("stack_ptr", 13'h00FF, view.stack_ptr);
      flg(FLG_RESTORE, 8'h00);
      chk("flags", 8'hE0, view.flags);
      pulse(1'b0);
      chk("pend", 2'b01, view.pend);
      chk("take", 1'b1, view.irq_take);
      flg(FLG_SEI, 8'h00);
      @(posedge aclk);
      #1;
      chk("take", 1'b0, view.irq_take);
      chk("pend", 2'b01, view.pend);
      stk(STK_CALL);
      chk("left", 4'h2, view.stk_left);
      wait_idle(pu, pl, early);
      chk("pushes", 2, pu);
      chk("stack_ptr", 13'h00FD, view.stack_ptr);
      $display("test irq done");
   endtask

   task automatic t_axi();
      // flags E8, index 42, acc 20, timer pending, stack low bits 3D
      axi_rd(REG_CORE, 32'hE842_207D, RESP_OKAY);
      axi_rd(REG_CTRL, 32'h0000_0001, RESP_OKAY);
      axi_rd(8'h10, 32'h0000_0000, RESP_SLV);
      axi_wr(8'h10, 32'hFFFF_FFFF, RESP_SLV);
      axi_wr(REG_FETCH, 32'h0000_1234, RESP_OKAY);
      axi_rd(REG_FETCH, 32'h0000_1FFC, RESP_OKAY);
      $display("test axi done");
   endtask

   // hang guard, far beyond the few hundred cycles the tests need
   initial begin
      repeat (20000) @(posedge aclk);
      mismatches++;
      $display("watchdog expired");
      final_report();
   end

   // main sequence
   initial begin
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      #1;
      t_reset(1'b0);
      t_alu();
      t_ea();
      t_stack();
      t_pc();
      t_irq();
      t_axi();
      t_reset(1'b1);
      final_report();
   end
endmodule // cpu_register_set_bench

// [dv/crs_seq_model.sv]
// sequencer model: drives the command word, loads the vector on entry
`timescale 1ns/100ps
module crs_seq_model
   import crs_pkg::*;
#(
   parameter logic [12:0] VEC_ADDR = 13'h1FFC
)(
   // clock
   input  wire logic      aclk,
   // register set side
   input  wire crs_view_s view,
   output crs_cmd_s       cmd
);
   crs_cmd_s req = '0;

   // vector load rides on the entry strobe, one cycle like the real core
   always_comb begin
      cmd = req;
      if (view.vec_fetch === 1'b1) begin
         cmd.fetch_op = FP_LOAD;
         cmd.fetch_d  = VEC_ADDR;
      end
   end

   // one-cycle request: launched after an edge, cleared after the next
   task automatic send(input crs_cmd_s c);
      @(posedge aclk);
      req <= c;
      @(posedge aclk);
      req <= '0;
      #1;
   endtask
endmodule // crs_seq_model

// [hdl/crs_core.sv]
// module: programmer-visible register set with debug axi4-lite view
`timescale 1ns/100ps
module crs_core
   import crs_pkg::*;
(
   // clock and reset
   input  wire logic              aclk,
   input  wire logic              aresetn,
   // sequencer side
   input  wire crs_cmd_s          cmd,
   input  wire logic              timer_irq_req,
   input  wire logic              ext_irq_req,
   output crs_view_s              view,
   // axi4-lite write
   input  wire logic [ADDR_W-1:0] s_axi_awaddr,
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,
   input  wire logic [31:0]       s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,
   output logic [1:0]             s_axi_bresp,
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,
   // axi4-lite read
   input  wire logic [ADDR_W-1:0] s_axi_araddr,
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,
   output logic [31:0]            s_axi_rdata,
   output logic [1:0]             s_axi_rresp,
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready
);

   typedef struct packed {
      crs_view_s         v;
      crs_st_e           st;
      logic              intr;
      logic              gate;
      logic              aw_full;
      logic [ADDR_W-1:0] aw_addr;
      logic              w_full;
      logic              w_bit;
      logic              w_strb;
      logic              awready;
      logic              wready;
      logic              bvalid;
      logic [1:0]        bresp;
      logic              arready;
      logic              rvalid;
      logic [31:0]       rdata;
      logic [1:0]        rresp;
   } crs_state_s;

   crs_state_s s;
   crs_state_s n;

   // whole next state in one place
   always_comb begin
      logic [8:0]  sum;
      logic [4:0]  half;
      logic [15:0] prod;
      logic        cy;
      logic [7:0]  res;
      logic        nz_upd;
      sum    = 9'h000;
      half   = 5'h00;
      prod   = 16'h0000;
      cy     = s.v.flags[F_C];
      res    = s.v.acc;
      nz_upd = 1'b0;
      n      = s;
      n.v.ea_valid  = 1'b0;
      n.v.push_stb  = 1'b0;
      n.v.pull_stb  = 1'b0;
      n.v.vec_fetch = 1'b0;

      // plain register loads
      if (cmd.acc_we) begin
         n.v.acc = cmd.acc_d;
      end
      if (cmd.idx_we) begin
         n.v.idx = cmd.idx_d;
      end

      // alu flag generation; alu write beats a plain load
      case (cmd.alu_op)
         ALU_ADD, ALU_ADC: begin
            if (cmd.alu_op == ALU_ADD) begin
               cy = 1'b0;
            end
            sum  = {1'b0, s.v.acc} + {1'b0, cmd.alu_b} + {8'h00, cy};
            half = {1'b0, s.v.acc[3:0]} + {1'b0, cmd.alu_b[3:0]}
                   + {4'h0, cy};
            res  = sum[7:0];
            n.v.flags[F_H] = half[4];
            n.v.flags[F_C] = sum[8];
            nz_upd = 1'b1;
         end
         ALU_SUB, ALU_SBC: begin
            if (cmd.alu_op == ALU_SUB) begin
               cy = 1'b0;
            end
            sum = {1'b0, s.v.acc} - {1'b0, cmd.alu_b} - {8'h00, cy};
            res = sum[7:0];
            n.v.flags[F_C] = sum[8]; // borrow out of bit 7
            nz_upd = 1'b1;
         end
         ALU_LOAD: begin
            res    = cmd.alu_b; // logical and data moves
            nz_upd = 1'b1;
         end
         ALU_SHIFT: begin
            res    = cmd.alu_b;
            n.v.flags[F_C] = cmd.cin_ext;
            nz_upd = 1'b1;
         end
         ALU_PROD: begin
            prod  = s.v.acc * s.v.idx;
            n.v.idx = prod[15:8];
            n.v.acc = prod[7:0];
            n.v.flags[F_H] = 1'b0;
            n.v.flags[F_C] = 1'b0;
         end
         default: begin
         end
      endcase
      if (nz_upd) begin
         n.v.acc = res;
         n.v.flags[F_N] = res[7];
         n.v.flags[F_Z] = (res == 8'h00);
      end

      // explicit flag instructions
      case (cmd.flg_op)
         FLG_SEI:     n.v.flags[F_I] = 1'b1;
         FLG_CLI:     n.v.flags[F_I] = 1'b0;
         FLG_CLC:     n.v.flags[F_C] = 1'b0;
         FLG_SEC:     n.v.flags[F_C] = 1'b1;
         FLG_CARRY:   n.v.flags[F_C] = cmd.cin_ext;
         FLG_RESTORE: n.v.flags[4:0] = cmd.flg_d[4:0];
         default: begin
         end
      endcase

      // fetch pointer, top bits never move
      case (cmd.fetch_op)
         FP_INC: begin
            n.v.fetch_pointer[12:0] = s.v.fetch_pointer[12:0]
                                      + 13'h0001;
         end
         FP_LOAD: n.v.fetch_pointer[12:0] = cmd.fetch_d;
         default: begin
         end
      endcase

      // effective address one cycle after the request
      case (cmd.ea_mode)
         EA_IX0: begin
            n.v.ea = {HI_ZERO, s.v.idx};
            n.v.ea_valid = 1'b1;
         end
         EA_IX1: begin
            n.v.ea = {HI_ZERO, s.v.idx} + {HI_ZERO, cmd.ea_off[7:0]};
            n.v.ea_valid = 1'b1;
         end
         EA_IX2: begin
            n.v.ea = cmd.ea_off + {HI_ZERO, s.v.idx};
            n.v.ea_valid = 1'b1;
         end
         default: begin
         end
      endcase

      // stack sequencer; only six low bits move, so it wraps
      case (s.st)
         ST_IDLE: begin
            case (cmd.stk_op)
               STK_PUSH: begin
                  n.v.stk_addr = {3'h0, s.v.stack_ptr};
                  n.v.stack_ptr[5:0] = s.v.stack_ptr[5:0] - 6'h01;
                  n.v.push_stb = 1'b1;
               end
               STK_PULL: begin
                  n.v.stack_ptr[5:0] = s.v.stack_ptr[5:0] + 6'h01;
                  n.v.stk_addr = {3'h0, n.v.stack_ptr};
                  n.v.pull_stb = 1'b1;
               end
               STK_RELOAD: n.v.stack_ptr = STK_INIT;
               STK_CALL: begin
                  n.v.stk_left = CNT_CALL;
                  n.st = ST_PUSH;
               end
               STK_INTR: begin
                  n.v.stk_left = CNT_INTR;
                  n.intr = 1'b1;
                  n.st = ST_PUSH;
                  // serve the external request first
                  if (s.v.pend[1]) begin
                     n.v.pend[1] = 1'b0;
                  end else begin
                     n.v.pend[0] = 1'b0;
                  end
               end
               STK_IRET: begin
                  n.v.stk_left = CNT_RET;
                  n.st = ST_PULL;
               end
               default: begin
               end
            endcase
         end
         ST_PUSH: begin
            n.v.stk_addr = {3'h0, s.v.stack_ptr};
            n.v.stack_ptr[5:0] = s.v.stack_ptr[5:0] - 6'h01;
            n.v.push_stb = 1'b1;
            n.v.stk_left = s.v.stk_left - 4'h1;
            if (s.v.stk_left == CNT_LAST) begin
               n.st = s.intr ? ST_VEC : ST_IDLE;
            end
         end
         ST_PULL: begin
            n.v.stack_ptr[5:0] = s.v.stack_ptr[5:0] + 6'h01;
            n.v.stk_addr = {3'h0, n.v.stack_ptr};
            n.v.pull_stb = 1'b1;
            n.v.stk_left = s.v.stk_left - 4'h1;
            if (s.v.stk_left == CNT_LAST) begin
               n.st = ST_IDLE;
            end
         end
         ST_VEC: begin
            n.v.flags[F_I] = 1'b1;
            n.v.vec_fetch = 1'b1;
            n.intr = 1'b0;
            n.st = ST_IDLE;
         end
         default: n.st = ST_IDLE;
      endcase
      n.v.stack_ptr[12:6] = STK_PAGE;
      n.v.busy = (n.st != ST_IDLE);

      // requests latch; a new one wins over the clear
      if (ext_irq_req) begin
         n.v.pend[1] = 1'b1;
      end
      if (timer_irq_req) begin
         n.v.pend[0] = 1'b1;
      end
      n.v.irq_take = (|n.v.pend) && !n.v.flags[F_I] && s.gate
                     && (n.st == ST_IDLE);

      // axi write: address and data in either order
      if (s_axi_awvalid && s.awready) begin
         n.aw_full = 1'b1;
         n.aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s.wready) begin
         n.w_full = 1'b1;
         n.w_bit  = s_axi_wdata[0];
         n.w_strb = s_axi_wstrb[0];
      end
      if (s.bvalid && s_axi_bready) begin
         n.bvalid = 1'b0;
      end
      if (s.aw_full && s.w_full && !s.bvalid) begin
         n.aw_full = 1'b0;
         n.w_full  = 1'b0;
         n.bvalid  = 1'b1;
         n.bresp   = RESP_OKAY;
         // the view registers are read only
         if (s.aw_addr == REG_CTRL) begin
            if (s.w_strb) begin
               n.gate = s.w_bit;
            end
         end else if (s.aw_addr != REG_CORE && s.aw_addr != REG_FETCH) begin
            n.bresp = RESP_SLV;
         end
      end
      n.awready = !n.aw_full;
      n.wready  = !n.w_full;

      // axi read, one outstanding
      if (s.rvalid && s_axi_rready) begin
         n.rvalid = 1'b0;
      end
      if (s_axi_arvalid && s.arready) begin
         n.rvalid = 1'b1;
         n.rresp  = RESP_OKAY;
         case (s_axi_araddr)
            REG_CTRL:  n.rdata = {31'h0000_0000, s.gate};
            REG_CORE:  n.rdata = {s.v.flags, s.v.idx, s.v.acc,
                                  s.v.pend, s.v.stack_ptr[5:0]};
            REG_FETCH: n.rdata = {16'h0000, s.v.fetch_pointer};
            default: begin
               n.rdata = 32'h0000_0000;
               n.rresp = RESP_SLV;
            end
         endcase
      end
      n.arready = !n.rvalid;

      // sync reset; mask set and stack reloaded
      if (!aresetn) begin
         n = '0;
         n.st = ST_IDLE;
         n.v.stack_ptr = STK_INIT;
         n.v.fetch_pointer[15:13] = FP_UPPER;
         n.v.flags[7:5] = FLG_UPPER;
         n.v.flags[F_I] = 1'b1;
         n.awready = 1'b1;
         n.wready  = 1'b1;
         n.arready = 1'b1;
      end
   end

   // the only state register
   always_ff @(posedge aclk) begin
      s <= n;
   end

   // outputs come straight from the state flops; no core address decode
   assign view          = s.v;
   assign s_axi_awready = s.awready;
   assign s_axi_wready  = s.wready;
   assign s_axi_bvalid  = s.bvalid;
   assign s_axi_bresp   = s.bresp;
   assign s_axi_arready = s.arready;
   assign s_axi_rvalid  = s.rvalid;
   assign s_axi_rdata   = s.rdata;
   assign s_axi_rresp   = s.rresp;

   // checks on the register set
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   stack_page_a: assert property (view.stack_ptr[12:6] == STK_PAGE)
      else $error("stack pointer left its page");
   fetch_upper_a: assert property (
      view.fetch_pointer[15:13] == FP_UPPER)
      else $error("fetch pointer upper bits nonzero");
   flag_upper_a: assert property (view.flags[7:5] == FLG_UPPER)
      else $error("flag upper bits not ones");
   reset_load_a: assert property (disable iff (1'b0)
      !aresetn |=> view.flags[F_I] && view.stack_ptr == STK_INIT)
      else $error("reset did not set mask and stack");
   push_step_a: assert property (view.push_stb |->
      view.stack_ptr[5:0] == view.stk_addr[5:0] - 6'h01)
      else $error("push did not decrement stack");
   call_two_a: assert property (s.st == ST_IDLE &&
      cmd.stk_op == STK_CALL |=> !view.push_stb ##1 view.push_stb[*2]
      ##1 !view.push_stb)
      else $error("call did not push two bytes");
   intr_mask_a: assert property (s.st == ST_IDLE &&
      cmd.stk_op == STK_INTR && !view.flags[F_I] && cmd.flg_op == FLG_NONE
      |=> !view.flags[F_I] ##1 (!view.flags[F_I] && view.push_stb)[*5]
      ##1 (view.flags[F_I] && view.vec_fetch))
      else $error("mask not set between pushes and vector");
   mask_block_a: assert property (view.flags[F_I] |-> !view.irq_take)
      else $error("interrupt offered while masked");
   half_carry_a: assert property (cmd.alu_op == ALU_ADD |=>
      view.flags[F_H] == ((5'({1'b0, $past(view.acc[3:0])})
      + 5'({1'b0, $past(cmd.alu_b[3:0])})) > 5'h0F))
      else $error("half carry wrong after add");
   ix0_addr_a: assert property (cmd.ea_mode == EA_IX0 |=>
      view.ea_valid && view.ea == {HI_ZERO, $past(view.idx)})
      else $error("indexed address high byte not zero");

   call_c: cover property (s.st == ST_IDLE && cmd.stk_op == STK_CALL);
   intr_c: cover property (view.vec_fetch);
   iret_c: cover property (s.st == ST_PULL && s.v.stk_left == CNT_LAST);
   wrap_c: cover property (view.push_stb && view.stk_addr[5:0] == 6'h00);
   axi_wr_c: cover property (s_axi_bvalid && s_axi_bready);

endmodule // crs_core

// [hdl/crs_pkg.sv]
// package: constants and types for the cpu register set
package crs_pkg;
   localparam int          ADDR_W    = 8;
   localparam logic [6:0]  STK_PAGE  = 7'b000_0011;
   localparam logic [12:0] STK_INIT  = 13'h00FF;
   localparam logic [2:0]  FP_UPPER  = 3'h0;
   localparam logic [2:0]  FLG_UPPER = 3'h7;
   localparam logic [7:0]  HI_ZERO   = 8'h00;
   localparam logic [3:0]  CNT_CALL  = 4'h2;
   localparam logic [3:0]  CNT_INTR  = 4'h5;
   localparam logic [3:0]  CNT_RET   = 4'h5;
   localparam logic [3:0]  CNT_LAST  = 4'h1;
   // flag bit positions
   localparam int          F_H = 4;
   localparam int          F_I = 3;
   localparam int          F_N = 2;
   localparam int          F_Z = 1;
   localparam int          F_C = 0;
   // debug register byte addresses
   localparam logic [7:0]  REG_CTRL  = 8'h00;
   localparam logic [7:0]  REG_CORE  = 8'h04;
   localparam logic [7:0]  REG_FETCH = 8'h08;
   localparam logic [1:0]  RESP_OKAY = 2'b00;
   localparam logic [1:0]  RESP_SLV  = 2'b10;

   typedef enum logic [2:0] {ALU_NONE, ALU_ADD, ALU_ADC, ALU_SUB, ALU_SBC,
      ALU_LOAD, ALU_SHIFT, ALU_PROD} crs_alu_e;
   typedef enum logic [2:0] {STK_NONE, STK_PUSH, STK_PULL, STK_RELOAD,
      STK_CALL, STK_INTR, STK_IRET} crs_stk_e;
   typedef enum logic [1:0] {FP_HOLD, FP_INC, FP_LOAD} crs_fp_e;
   typedef enum logic [2:0] {FLG_NONE, FLG_SEI, FLG_CLI, FLG_CLC, FLG_SEC,
      FLG_RESTORE, FLG_CARRY} crs_flg_e;
   typedef enum logic [1:0] {EA_NONE, EA_IX0, EA_IX1, EA_IX2} crs_ea_e;
   typedef enum logic [3:0] {ST_IDLE = 4'b0001, ST_PUSH = 4'b0010,
      ST_PULL = 4'b0100, ST_VEC = 4'b1000} crs_st_e;

   // one cycle command from the sequencer
   typedef struct packed {
      logic        acc_we;
      logic [7:0]  acc_d;
      logic        idx_we;
      logic [7:0]  idx_d;
      crs_alu_e    alu_op;
      logic [7:0]  alu_b;
      logic        cin_ext;
      crs_stk_e    stk_op;
      crs_fp_e     fetch_op;
      logic [12:0] fetch_d;
      crs_flg_e    flg_op;
      logic [7:0]  flg_d;
      crs_ea_e     ea_mode;
      logic [15:0] ea_off;
   } crs_cmd_s;

   // registered view toward the sequencer
   typedef struct packed {
      logic [7:0]  acc;
      logic [7:0]  idx;
      logic [12:0] stack_ptr;
      logic [15:0] fetch_pointer;
      logic [7:0]  flags;
      logic [15:0] ea;
      logic        ea_valid;
      logic [15:0] stk_addr;
      logic        push_stb;
      logic        pull_stb;
      logic [3:0]  stk_left;
      logic        vec_fetch;
      logic        busy;
      logic [1:0]  pend;
      logic        irq_take;
   } crs_view_s;
endpackage : crs_pkg
